// [inc/lsw_consts.vh]
// Constants of the lamp switch serial front end and mode supervisor.
// Assumes inclusion by its bare name from the core design files.
`ifndef LSW_CONSTS_VH
`define LSW_CONSTS_VH
`define LSW_WORD_BITS      16
`define LSW_ADDR_MSB       14
`define LSW_ADDR_LSB       10
`define LSW_WD_BIT         15
`define LSW_NUM_REGS       32
`define LSW_CTRL_ADDR      5'h00
`define LSW_CFG_ADDR       5'h01
`define LSW_DUTY_ADDR      5'h02
`define LSW_CFG_RESET      16'h0000
`define LSW_CFG_VDDFAIL    0
`define LSW_CFG_OVGATE     1
`define LSW_CFG_DIR_DIS    2
`define LSW_MODE_SLEEP     2'h0
`define LSW_MODE_NORMAL    2'h1
`define LSW_MODE_FAILSAFE  2'h2
`define LSW_MODE_FAULT     2'h3
`define LSW_CLK_MHZ        200
`define LSW_DEGLITCH_NS    1000
`define LSW_DEGLITCH_CYC   ((`LSW_DEGLITCH_NS * `LSW_CLK_MHZ) / 1000)
`define LSW_PWM_MIN_HZ     100
`define LSW_PWM_MAX_HZ     400
`define LSW_PWM_STEPS      128
`define LSW_PWM_DIV        ((`LSW_CLK_MHZ * 1000000) / (200 * 128))
`endif

// [core/lsw_regmem.v]
// Register store of the serial front end: 32 words of 16 bits.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/1ps
`include "lsw_consts.vh"
module lsw_regmem
#(
  parameter AW = 5,
  parameter DW = 16
)
(
  input  wire          clk,     // System clock.
  input  wire          clr,     // Clear all words to default.
  input  wire          we,      // Write strobe.
  input  wire [AW-1:0] waddr,   // Write address.
  input  wire [DW-1:0] wdata,   // Write data.
  input  wire [AW-1:0] raddr,   // Read address.
  output reg  [DW-1:0] rdata    // Registered read data.
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  genvar g;
  generate
    for (g = 0; g < (1<<AW); g = g + 1)
    begin : gw
      always @(posedge clk)
      begin
        if (clr)
          mem[g] <= `LSW_CFG_RESET;
        else if (we && waddr == g)
          mem[g] <= wdata;
      end
    end
  endgenerate
  always @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule

// [core/lsw_front.v]
// Serial front end and operating mode supervisor of a quad lamp switch.
// Assumes all pins but SYS_RST are asynchronous to CLK; all others but the fault flag pins are double synchronised.
// Overview of operation
// RQ1: Input bits captured on serial clock fall.
// RQ2: Sixteen bits per frame, MSB first.
// RQ3: Five-bit address field selects target register.
// RQ4: Serial output high-impedance while select high.
// RQ5: Output changes on rise, host samples fall.
// RQ6: Supply loss with detection enabled: fail-safe.
// RQ7: Strap open: watchdog on, timeout follows inputs.
// RQ8: Strap grounded: watchdog off, supply loss only.
// RQ9: Wake is OR of reset, wake, inputs.
// RQ10: Fail is supply loss or unstrapped timeout.
// RQ11: Fault ORs channel flags, undervoltage, gated overvoltage.
// RQ12: No wake means sleep, outputs off.
// RQ13: Wake without fail or fault: normal.
// RQ14: Wake, fail, no fault: fail-safe mode.
// RQ15: Fault mode: faulted outputs off, autoretry.
// RQ16: Fail-safe drives outputs from inputs, defaults.
// RQ17: Normal: serial commands, dimming 100 to 400 Hz.
// RQ18: Select rise writes word to addressed register.
// RQ19: Select fall loads status for sending.
// RQ20: Serial lines ignored while select high.
// RQ21: Direct inputs deglitched on internal clock; only wake uses the filtered inputs, fail-safe outputs follow them unfiltered.
`timescale 1ns/1ps
`include "lsw_consts.vh"
module lsw_front
#(
  parameter NCH    = 4,
  parameter FILT_N = `LSW_DEGLITCH_CYC
)
(
  input  wire           CLK,            // 200 MHz clock.
  input  wire           SYS_RST,        // Synchronous reset, high.
  input  wire           SCLK,           // Serial clock pin.
  input  wire           CS_N,           // Chip select pin, low.
  input  wire           SDI,            // Serial data in.
  output reg            SDO_O,          // Serial data out value.
  output reg            SDO_OE_N,       // Output enable, low drives.
  input  wire           RESET_IN,       // Reset/wake pin.
  input  wire           WAKE_IN,        // Wake pin.
  input  wire [NCH-1:0] DIRECT_IN,      // Direct input pins.
  input  wire           FAILSAFE_STRAP, // High when strap open.
  input  wire           VDD_FAIL,       // Logic supply lost.
  input  wire           WD_TIMEOUT,     // Watchdog timeout event.
  input  wire [NCH-1:0] OVERCURRENT_FLAG, // Per channel.
  input  wire [NCH-1:0] OVERTEMP_FLAG,  // Per channel.
  input  wire [NCH-1:0] SHORT_CIRCUIT_FLAG, // Per channel.
  input  wire           UNDERVOLTAGE_FLAG, // Undervoltage.
  input  wire           OVERVOLTAGE_FLAG,  // Overvoltage.
  output reg  [NCH-1:0] SWITCH_OUT,     // Lamp switch drives.
  output reg  [1:0]     MODE,           // Operating mode code.
  output reg            WD_ENABLE,      // Watchdog may run.
  output reg            FAULT_FLAG_PIN_N, // Fault, active low.
  output reg            RETRY_REQ       // Autoretry request.
);
  // Synchronisers: the first stage feeds only the second.
  localparam NS = 6 + NCH;
  reg [NS-1:0] s1_q;
  reg [NS-1:0] s2_q;
  always @(posedge CLK)
  begin
    s1_q <= {VDD_FAIL, WD_TIMEOUT, WAKE_IN, RESET_IN, SDI, SCLK,
             DIRECT_IN} & {NS{1'b1}};
    s2_q <= s1_q;
  end
  wire [NCH-1:0] din_s  = s2_q[NCH-1:0];
  wire           sclk_s = s2_q[NCH];
  wire           sdi_s  = s2_q[NCH+1];
  wire           rst_s  = s2_q[NCH+2];
  wire           wake_s = s2_q[NCH+3];
  wire           wdto_s = s2_q[NCH+4];
  wire           vddf_s = s2_q[NCH+5];
  reg  [1:0] cs1_q;
  reg        strap1_q;
  reg        strap2_q;
  always @(posedge CLK)
  begin
    cs1_q    <= {cs1_q[0], CS_N};
    strap1_q <= FAILSAFE_STRAP;
    strap2_q <= strap1_q;
  end
  wire cs_s = cs1_q[1];

  reg sclk_q;
  reg cs_q;
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_q   <= cs_s;
    end
  end
  wire sclk_fall = sclk_q & ~sclk_s;
  wire sclk_rise = ~sclk_q & sclk_s;
  wire cs_fall   = cs_q & ~cs_s;
  wire cs_rise   = ~cs_q & cs_s;

  // Deglitch filters on the direct inputs.
  localparam [15:0] FILT_LAST = FILT_N - 1;
  reg [NCH-1:0] in_on_q;
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1)
    begin : gflt
      reg [15:0] cnt_q;
      always @(posedge CLK)
      begin
        if (SYS_RST)
        begin
          cnt_q      <= 16'h0000;
          in_on_q[c] <= 1'b0;
        end
        else if (din_s[c] == in_on_q[c])
          cnt_q <= 16'h0000;
        else if (cnt_q == FILT_LAST)
        begin
          cnt_q      <= 16'h0000;
          in_on_q[c] <= din_s[c]; // RQ21
        end
        else
          cnt_q <= cnt_q + 16'h0001;
      end
    end
  endgenerate

  // Shift registers and frame counter.
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg [4:0]  bits_q;
  reg [15:0] stat_word;
  wire       frame_ok = (bits_q == 5'h10);
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      rx_q     <= 16'h0000;
      tx_q     <= 16'h0000;
      bits_q   <= 5'h00;
      SDO_O    <= 1'b0;
      SDO_OE_N <= 1'b1;
    end
    else if (cs_s)
    begin
      SDO_OE_N <= 1'b1; // RQ4 RQ20
      bits_q   <= 5'h00;
    end
    else if (cs_fall)
    begin
      tx_q     <= {stat_word[14:0], 1'b0}; // RQ19
      SDO_O    <= stat_word[15]; // RQ2
      SDO_OE_N <= 1'b0; // RQ4
    end
    else
    begin
      if (sclk_fall)
      begin
        rx_q <= {rx_q[14:0], sdi_s}; // RQ1 RQ2
        if (bits_q != 5'h1F)
          bits_q <= bits_q + 5'h01;
      end
      if (sclk_rise && bits_q != 5'h00)
      begin
        SDO_O <= tx_q[15]; // RQ5
        tx_q  <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // Register store; a frame of other than sixteen bits is discarded.
  wire [4:0] waddr = rx_q[`LSW_ADDR_MSB:`LSW_ADDR_LSB]; // RQ3
  wire       reg_we = cs_rise & frame_ok; // RQ18 RQ2
  wire       in_fs;
  wire [15:0] cfg_rd;
  reg  [15:0] ctrl_q;
  reg  [6:0]  duty_q;
  lsw_regmem #(.AW(5), .DW(16)) u_mem
  (
    .clk   (CLK),
    .clr   (SYS_RST | in_fs), // RQ16
    .we    (reg_we),
    .waddr (waddr),
    .wdata (rx_q),
    .raddr (`LSW_CFG_ADDR),
    .rdata (cfg_rd)
  );
  // Duty has a word of its own: the address field leaves no room beside
  // the on bits for a seven-bit duty value.
  always @(posedge CLK)
  begin
    if (SYS_RST | in_fs)
    begin
      ctrl_q <= `LSW_CFG_RESET; // RQ16
      duty_q <= 7'h00;
    end
    else
    begin
      if (reg_we && waddr == `LSW_CTRL_ADDR)
        ctrl_q <= rx_q;
      if (reg_we && waddr == `LSW_DUTY_ADDR)
        duty_q <= rx_q[6:0]; // RQ17
    end
  end
  wire vddf_en = cfg_rd[`LSW_CFG_VDDFAIL];
  wire ov_gate = cfg_rd[`LSW_CFG_OVGATE];

  // Fail latch: held until a frame with the watchdog bit set, or until the strap is grounded with no enabled supply loss.
  wire fail_ev = (vddf_s & vddf_en) // RQ6 RQ8 RQ10
               | (wdto_s & strap2_q); // RQ7 RQ10
  reg  fail_q;
  always @(posedge CLK)
  begin
    if (SYS_RST)
      fail_q <= 1'b0;
    else if (fail_ev)
      fail_q <= 1'b1;
    else if (reg_we && rx_q[`LSW_WD_BIT])
      fail_q <= 1'b0;
    else if (!strap2_q && !(vddf_s & vddf_en))
      fail_q <= 1'b0; // RQ8
  end
  wire fail  = fail_q | fail_ev;
  wire [NCH-1:0] ch_fault = OVERCURRENT_FLAG | OVERTEMP_FLAG
                          | SHORT_CIRCUIT_FLAG;
  wire fault = (|ch_fault) | UNDERVOLTAGE_FLAG
             | (OVERVOLTAGE_FLAG & ov_gate); // RQ11
  wire wakeup = rst_s | wake_s | (|in_on_q); // RQ9
  assign in_fs = wakeup & fail & ~fault;

  // Dimming timebase: 128 steps at 200 Hz, inside 100 to 400 Hz.
  localparam [19:0] PWM_LAST = `LSW_PWM_DIV - 1;
  reg [19:0] div_q;
  reg [6:0]  step_q;
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      div_q  <= 20'h0_0000;
      step_q <= 7'h00;
    end
    else if (div_q == PWM_LAST)
    begin
      div_q  <= 20'h0_0000;
      step_q <= step_q + 7'h01; // RQ17
    end
    else
      div_q <= div_q + 20'h0_0001;
  end
  wire [6:0] duty = duty_q;
  wire       pwm_on = (duty == 7'h7F) | (step_q <= duty); // RQ17

  reg [1:0] mode_d;
  always @*
  begin
    if (!wakeup)
      mode_d = `LSW_MODE_SLEEP; // RQ12
    else if (fault)
      mode_d = `LSW_MODE_FAULT; // RQ15
    else if (fail)
      mode_d = `LSW_MODE_FAILSAFE; // RQ14
    else
      mode_d = `LSW_MODE_NORMAL; // RQ13
  end

  reg [NCH-1:0] out_d;
  always @*
  begin
    case (mode_d)
      `LSW_MODE_NORMAL:
        out_d = ctrl_q[NCH-1:0] & {NCH{pwm_on}}; // RQ17
      `LSW_MODE_FAILSAFE:
        out_d = din_s; // RQ14 RQ16
      `LSW_MODE_FAULT:
        out_d = ctrl_q[NCH-1:0] & ~ch_fault
              & {NCH{~UNDERVOLTAGE_FLAG}}; // RQ15
      default:
        out_d = {NCH{1'b0}}; // RQ12
    endcase
  end

  always @*
  begin
    stat_word = {mode_d, fail, fault, wakeup, 3'b000,
                 ch_fault, SWITCH_OUT} & 16'hFFFF;
  end

  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      SWITCH_OUT       <= {NCH{1'b0}};
      MODE             <= `LSW_MODE_SLEEP;
      WD_ENABLE        <= 1'b0;
      FAULT_FLAG_PIN_N <= 1'b1;
      RETRY_REQ        <= 1'b0;
    end
    else
    begin
      SWITCH_OUT       <= out_d;
      MODE             <= mode_d;
      WD_ENABLE        <= strap2_q & (mode_d == `LSW_MODE_NORMAL); // RQ13
      FAULT_FLAG_PIN_N <= ~(wakeup & fault);
      RETRY_REQ        <= (mode_d == `LSW_MODE_FAULT); // RQ15
    end
  end
endmodule

// [verification/lsw_front_sva.sv]
// Port checker of the lamp switch serial front end and mode supervisor.
// Assumes it is bound to lsw_front with the same deglitch count.
`timescale 1ns/1ps
`include "lsw_consts.vh"
module lsw_front_sva
#(
  parameter FILT_N = 4
)
(
  input wire       CLK,              // Clock.
  input wire       SYS_RST,          // Reset.
  input wire       CS_N,             // Select.
  input wire       SDO_OE_N,         // Drive enable.
  input wire       RESET_IN,         // Wake source.
  input wire       WAKE_IN,          // Wake source.
  input wire [3:0] DIRECT_IN,        // Direct inputs.
  input wire       FAILSAFE_STRAP,   // Strap.
  input wire [3:0] OVERCURRENT_FLAG, // Flags.
  input wire [3:0] SWITCH_OUT,       // Drives.
  input wire [1:0] MODE,             // Mode.
  input wire       WD_ENABLE,        // Watchdog.
  input wire       FAULT_FLAG_PIN_N, // Fault pin.
  input wire       RETRY_REQ         // Retry.
);
  // Slack covers the two-stage synchronisers and the deglitch stage.
  localparam int WB = FILT_N + 12;
  wire awake = RESET_IN || WAKE_IN || DIRECT_IN != 4'h0;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  oe_idle_a: assert property (CS_N [*8] |-> SDO_OE_N)
    else $error("Serial output driven while deselected.");
  oe_drive_a: assert property ((!CS_N) [*6] |-> !SDO_OE_N)
    else $error("Serial output not driven while selected.");
  sleep_enter_a: assert property ((!awake) [*8] |-> ##[0:WB] MODE ==
    `LSW_MODE_SLEEP) else $error("No sleep without wake sources.");
  sleep_off_a: assert property (MODE == `LSW_MODE_SLEEP &&
    $past(MODE) == `LSW_MODE_SLEEP |-> SWITCH_OUT == 4'h0)
    else $error("Output on in sleep.");
  fault_enter_a: assert property ((OVERCURRENT_FLAG != 0 && awake) [*4]
    |-> ##[0:8] MODE == `LSW_MODE_FAULT) else $error("No fault mode.");
  fault_pin_a: assert property ((MODE == `LSW_MODE_FAULT) [*2]
    |-> !FAULT_FLAG_PIN_N && RETRY_REQ) else $error("Fault pins wrong.");
  follow_in_a: assert property ((MODE == `LSW_MODE_FAILSAFE &&
    $stable(DIRECT_IN)) [*8] |-> ##[0:WB] SWITCH_OUT == DIRECT_IN)
    else $error("Outputs do not follow direct inputs.");
  wd_on_a: assert property ((MODE == `LSW_MODE_NORMAL &&
    FAILSAFE_STRAP) [*6] |-> WD_ENABLE) else $error("Watchdog off.");
  wd_off_a: assert property ((!FAILSAFE_STRAP) [*6] |-> !WD_ENABLE)
    else $error("Watchdog on with strap grounded.");
endmodule
bind lsw_front lsw_front_sva #(.FILT_N(FILT_N)) chk_i
(
  .CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SDO_OE_N(SDO_OE_N),
  .RESET_IN(RESET_IN), .WAKE_IN(WAKE_IN), .DIRECT_IN(DIRECT_IN),
  .FAILSAFE_STRAP(FAILSAFE_STRAP), .OVERCURRENT_FLAG(OVERCURRENT_FLAG),
  .SWITCH_OUT(SWITCH_OUT), .MODE(MODE), .WD_ENABLE(WD_ENABLE),
  .FAULT_FLAG_PIN_N(FAULT_FLAG_PIN_N), .RETRY_REQ(RETRY_REQ)
);

// [verification/lsw_host.sv]
// Host controller model: serial master with an 80 ns serial clock.
// Assumes each transfer is started on a system clock falling edge.
`timescale 1ns/1ps
module lsw_host
(
  output logic      sclk, // Serial clock, idles low.
  output logic      cs_n, // Chip select, low.
  output logic      sdi,  // Data to device.
  input  wire logic sdo   // Resolved data from device.
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    // Pulses while deselected would corrupt the frame if counted.
    repeat (2)
    begin
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      #40 sclk = 1'b1;
      sdi = tx[i];
      #40 sclk = 1'b0;
      rx[i] = sdo;
    end
    #40 cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule

// [verification/tb.sv]
// Self-checking bench of the lamp switch front end and mode supervisor.
// Assumes the host model and a short deglitch count of four cycles.
`timescale 1ns/1ps
`include "lsw_consts.vh"
module tb;
  logic clk = 1'b0, sys_rst = 1'b1, rst_in = 1'b0, wake = 1'b0;
  logic strap = 1'b1, vdd_fail = 1'b0, wd_to = 1'b0, sdo_last = 1'b0;
  logic low_v = 1'b0, high_v = 1'b0;
  logic [3:0] din = 4'h0, cur_flt = 4'h0, temp_flt = 4'h0, short_flt = 4'h0;
  logic [15:0] rx;
  wire sclk, cs_n, sdi, sdo_o, sdo_oe_n, wd_en, flt_n, retry, sdo;
  wire [3:0] sw;
  wire [1:0] mode;
  int n_errors = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  // A released line shows the inverse of its last driven value.
  always @(posedge clk)
    if (!sdo_oe_n)
      sdo_last <= sdo_o;
  assign sdo = sdo_oe_n ? ~sdo_last : sdo_o;
  lsw_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  lsw_front #(.FILT_N(4)) dut
  (
    .CLK(clk), .SYS_RST(sys_rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
    .SDO_O(sdo_o), .SDO_OE_N(sdo_oe_n), .RESET_IN(rst_in), .WAKE_IN(wake),
    .DIRECT_IN(din), .FAILSAFE_STRAP(strap), .VDD_FAIL(vdd_fail),
    .WD_TIMEOUT(wd_to), .OVERCURRENT_FLAG(cur_flt), .OVERTEMP_FLAG(temp_flt),
    .SHORT_CIRCUIT_FLAG(short_flt), .UNDERVOLTAGE_FLAG(low_v),
    .OVERVOLTAGE_FLAG(high_v), .SWITCH_OUT(sw), .MODE(mode),
    .WD_ENABLE(wd_en), .FAULT_FLAG_PIN_N(flt_n), .RETRY_REQ(retry)
  );
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int i;
    for (i = 0; i < 400 && mode !== m; i++)
      @(negedge clk);
    chk(mode === m, "mode not reached");
    if (mode !== m)
      end_of_test();
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset();
    sys_rst = 1'b1;
    idle(8);
    chk(sdo_oe_n === 1'b1 && mode === `LSW_MODE_SLEEP, "reset");
    sys_rst = 1'b0;
    idle(4);
  endtask
  task automatic t_status();
    wake = 1'b1;
    wait_mode(`LSW_MODE_NORMAL);
    host.xfer(16'h8000, rx);
    chk(rx === 16'h4800, "normal status");
  endtask
  task automatic t_supply();
    vdd_fail = 1'b1;
    idle(40);
    chk(mode === `LSW_MODE_NORMAL, "detect off");
    vdd_fail = 1'b0;
    host.xfer(16'h8401, rx);
    vdd_fail = 1'b1;
    wait_mode(`LSW_MODE_FAILSAFE);
    din = 4'ha;
    idle(20);
    chk(sw === 4'ha, "outputs follow inputs");
    vdd_fail = 1'b0;
    host.xfer(16'h8000, rx);
    chk(rx === 16'ha80a, "fail-safe status");
    wait_mode(`LSW_MODE_NORMAL);
    din = 4'h0;
    vdd_fail = 1'b1;
    idle(40);
    chk(mode === `LSW_MODE_NORMAL, "config defaults");
    vdd_fail = 1'b0;
  endtask
  task automatic t_watchdog();
    wd_to = 1'b1;
    idle(4);
    wd_to = 1'b0;
    wait_mode(`LSW_MODE_FAILSAFE);
    host.xfer(16'h8000, rx);
    wait_mode(`LSW_MODE_NORMAL);
    strap = 1'b0;
    idle(10);
    chk(wd_en === 1'b0, "watchdog off");
    wd_to = 1'b1;
    idle(4);
    wd_to = 1'b0;
    idle(40);
    chk(mode === `LSW_MODE_NORMAL, "timeout ignored");
    strap = 1'b1;
    idle(10);
    chk(wd_en === 1'b1, "watchdog on");
  endtask
  task automatic t_sleep();
    wake = 1'b0;
    wait_mode(`LSW_MODE_SLEEP);
    chk(sw === 4'h0, "sleep outputs");
    rst_in = 1'b1;
    wait_mode(`LSW_MODE_NORMAL);
    rst_in = 1'b0;
    wait_mode(`LSW_MODE_SLEEP);
    din = 4'h2;
    wait_mode(`LSW_MODE_NORMAL);
  endtask
  task automatic t_fault();
    host.xfer(16'h887F, rx);
    host.xfer(16'h800F, rx);
    chk(sw === 4'hf, "serial command");
    high_v = 1'b1;
    idle(40);
    chk(mode === `LSW_MODE_NORMAL, "overvoltage gated");
    high_v = 1'b0;
    host.xfer(16'h8402, rx);
    high_v = 1'b1;
    wait_mode(`LSW_MODE_FAULT);
    high_v = 1'b0;
    wait_mode(`LSW_MODE_NORMAL);
    cur_flt = 4'h4;
    wait_mode(`LSW_MODE_FAULT);
    chk(flt_n === 1'b0 && retry === 1'b1, "fault pins");
    chk(sw === 4'hb, "faulted output off");
    host.xfer(16'h800F, rx);
    chk(rx === 16'hd84b, "fault status");
    cur_flt = 4'h0;
    wait_mode(`LSW_MODE_NORMAL);
    low_v = 1'b1;
    wait_mode(`LSW_MODE_FAULT);
    chk(sw === 4'h0, "undervoltage outputs off");
    low_v = 1'b0;
    wait_mode(`LSW_MODE_NORMAL);
    temp_flt = 4'h1;
    wait_mode(`LSW_MODE_FAULT);
    chk(sw === 4'he, "overtemperature output off");
    temp_flt = 4'h0;
    wait_mode(`LSW_MODE_NORMAL);
    short_flt = 4'h8;
    wait_mode(`LSW_MODE_FAULT);
    chk(sw === 4'h7, "short circuit output off");
    short_flt = 4'h0;
    wait_mode(`LSW_MODE_NORMAL);
  endtask
  initial
  begin
    @(negedge clk);
    t_reset();
    t_status();
    t_supply();
    t_watchdog();
    t_sleep();
    t_fault();
    t_reset();
    wait_mode(`LSW_MODE_NORMAL);
    chk(sw === 4'h0, "control cleared by reset");
    end_of_test();
  end
endmodule
